// file: core/pwc_compare.sv
`timescale 1ns/1ps
module pwc_compare
	import pwc_pkg::*;
(
	pwc_cmp_if.comparer cmp
);

	// ----------------------------------------
	// signed word relation
	// ----------------------------------------
	function automatic logic pwc_less(input logic [15:0] a, input logic [15:0] b);
		pwc_less = $signed(a) < $signed(b);
	endfunction

	logic lt_ab;
	logic lt_ba;

	always_comb begin
		lt_ab = pwc_less(cmp.first_source_word, cmp.second_source_word);
		lt_ba = pwc_less(cmp.second_source_word, cmp.first_source_word);
		case (cmp.rel)
			REL_EQ:  cmp.cont = cmp.first_source_word == cmp.second_source_word; // [RQ1]
			REL_NE:  cmp.cont = cmp.first_source_word != cmp.second_source_word; // [RQ2]
			REL_GT:  cmp.cont = lt_ba;  // [RQ3]
			REL_LE:  cmp.cont = !lt_ba; // [RQ4]
			REL_LT:  cmp.cont = lt_ab;  // [RQ5]
			REL_GE:  cmp.cont = !lt_ab; // [RQ6]
			default: cmp.cont = 1'b0;
		endcase
	end

endmodule

// file: core/pwc_word_unit.sv
`timescale 1ns/1ps
// Operation
// [RQ1] equal compare: continuity when first equals second source word
// [RQ2] not-equal compare: continuity when the two source words differ
// [RQ3] greater compare: continuity when first exceeds second
// [RQ4] less-or-equal compare: continuity when first does not exceed second
// [RQ5] less compare: continuity when first is smaller than second
// [RQ6] greater-or-equal compare: continuity when first is not smaller
// [RQ7] compares use 16-bit words, in start, series and parallel forms
// [RQ8] add: source plus destination, or first plus second source
// [RQ9] subtract: source minus destination, or first minus second source
// [RQ10] multiply: 32-bit product, upper half into next word
// [RQ11] divide: quotient to destination, remainder to next word
// [RQ12] series ANDs, parallel ORs, start begins a new result
// [RQ13] pulse variants execute once on off-to-on condition only
// [RQ14] transfer copies source to destination, pulse variant on rising edge
// [RQ15] add and subtract wrap; divide by zero writes nothing, flags error
module pwc_word_unit
	import pwc_pkg::*;
(
	input  wire logic         i_core_clk,
	input  wire logic         i_arst_n,
	input  wire logic         i_exec,
	input  wire pwc_op_type   i_op,
	input  wire pwc_rel_type  i_rel,
	input  wire pwc_form_type i_form,
	input  wire logic         i_pulse,
	input  wire logic         i_three,
	input  wire logic         i_cond,
	input  wire logic [3:0]   i_slot,
	input  wire logic [15:0]  i_src1,
	input  wire logic [15:0]  i_src2,
	input  wire logic [15:0]  i_dst,
	input  wire logic         i_err_clr,
	output logic              o_done,
	output logic              o_result,
	output logic              o_wr_lo,
	output logic              o_wr_hi,
	output logic [15:0]       o_lo_data,
	output logic [15:0]       o_hi_data,
	output logic              o_op_error
);

	// ----------------------------------------
	// comparator
	// ----------------------------------------
	pwc_cmp_if cmp_bus ();

	assign cmp_bus.first_source_word  = i_src1; // [RQ7]
	assign cmp_bus.second_source_word = i_src2;
	assign cmp_bus.rel                = i_rel;

	pwc_compare u_compare (
		.cmp (cmp_bus.comparer)
	);

	// ----------------------------------------
	// datapath
	// ----------------------------------------
	logic               done_q;
	logic               done_d;
	logic               result_q;
	logic               result_d;
	logic               wr_lo_q;
	logic               wr_lo_d;
	logic               wr_hi_q;
	logic               wr_hi_d;
	logic [15:0]        lo_q;
	logic [15:0]        lo_d;
	logic [15:0]        hi_q;
	logic [15:0]        hi_d;
	logic               err_q;
	logic               err_d;
	logic [SLOTS-1:0]   edge_q;
	logic [SLOTS-1:0]   edge_d;
	logic               fire;
	logic [15:0]        op_b;
	logic [15:0]        sum;
	logic [15:0]        diff;
	logic signed [31:0] prod;
	logic [15:0]        quot;
	logic [15:0]        rem;

	always_comb begin
		// rising-edge gate for pulse variants
		fire   = i_cond && (!i_pulse || !edge_q[i_slot]); // [RQ13] [RQ14]
		// two-operand forms take the destination as second operand
		op_b   = i_three ? i_src2 : i_dst; // [RQ8] [RQ9]
		sum    = i_src1 + op_b;            // [RQ15]
		diff   = i_src1 - op_b;            // [RQ15]
		prod   = $signed(i_src1) * $signed(i_src2); // [RQ10]
		quot   = WORD_ZERO;
		rem    = WORD_ZERO;
		if (i_src2 != WORD_ZERO) begin
			quot = 16'($signed(i_src1) / $signed(i_src2)); // [RQ11]
			rem  = 16'($signed(i_src1) % $signed(i_src2));
		end

		done_d   = i_exec;
		result_d = result_q;
		wr_lo_d  = 1'b0;
		wr_hi_d  = 1'b0;
		lo_d     = lo_q;
		hi_d     = hi_q;
		err_d    = err_q && !i_err_clr;
		edge_d   = edge_q;

		if (i_exec) begin
			edge_d[i_slot] = i_cond; // [RQ13]
			if (i_op == OP_CMP) begin
				case (i_form)
					FORM_START:    result_d = cmp_bus.cont;             // [RQ12]
					FORM_SERIES:   result_d = result_q & cmp_bus.cont;  // [RQ12]
					FORM_PARALLEL: result_d = result_q | cmp_bus.cont;  // [RQ12]
					default:       result_d = result_q;
				endcase
			end else if (fire) begin
				case (i_op)
					OP_MOV: begin
						wr_lo_d = 1'b1;
						lo_d    = i_src1; // [RQ14]
					end
					OP_ADD: begin
						wr_lo_d = 1'b1;
						lo_d    = sum; // [RQ8]
					end
					OP_SUB: begin
						wr_lo_d = 1'b1;
						lo_d    = diff; // [RQ9]
					end
					OP_MUL: begin
						wr_lo_d = 1'b1;
						wr_hi_d = 1'b1;
						lo_d    = prod[15:0];
						hi_d    = prod[31:16]; // [RQ10]
					end
					OP_DIV: begin
						if (i_src2 == WORD_ZERO) begin
							err_d = 1'b1; // [RQ15]
						end else begin
							wr_lo_d = 1'b1;
							wr_hi_d = 1'b1;
							lo_d    = quot; // [RQ11]
							hi_d    = rem;
						end
					end
					default: begin
						wr_lo_d = 1'b0;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			done_q   <= 1'b0;
			result_q <= RESULT_RST;
			wr_lo_q  <= 1'b0;
			wr_hi_q  <= 1'b0;
			lo_q     <= WORD_RST;
			hi_q     <= WORD_RST;
			err_q    <= 1'b0;
			edge_q   <= EDGE_RST;
		end else begin
			done_q   <= done_d;
			result_q <= result_d;
			wr_lo_q  <= wr_lo_d;
			wr_hi_q  <= wr_hi_d;
			lo_q     <= lo_d;
			hi_q     <= hi_d;
			err_q    <= err_d;
			edge_q   <= edge_d;
		end
	end

	assign o_done     = done_q;
	assign o_result   = result_q;
	assign o_wr_lo    = wr_lo_q;
	assign o_wr_hi    = wr_hi_q;
	assign o_lo_data  = lo_q;
	assign o_hi_data  = hi_q;
	assign o_op_error = err_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_cmp_start(pwc_rel_type r);
		i_exec && i_op == OP_CMP && i_form == FORM_START && i_rel == r;
	endsequence

	sequence s_arith(pwc_op_type o);
		i_exec && i_op == o && i_cond && !i_pulse;
	endsequence

	property p_eq;
		s_cmp_start(REL_EQ) |=> o_result == ($past(i_src1) == $past(i_src2));
	endproperty
	a_eq: assert property (p_eq) else $error("equal compare wrong"); // [RQ1]

	property p_ne;
		s_cmp_start(REL_NE) |=> o_result == ($past(i_src1) != $past(i_src2));
	endproperty
	a_ne: assert property (p_ne) else $error("not-equal compare wrong"); // [RQ2]

	property p_gt;
		s_cmp_start(REL_GT) |=> o_result == ($signed($past(i_src1)) > $signed($past(i_src2)));
	endproperty
	a_gt: assert property (p_gt) else $error("greater compare wrong"); // [RQ3]

	property p_le;
		s_cmp_start(REL_LE) |=> o_result == ($signed($past(i_src1)) <= $signed($past(i_src2)));
	endproperty
	a_le: assert property (p_le) else $error("less-equal compare wrong"); // [RQ4]

	property p_lt;
		s_cmp_start(REL_LT) |=> o_result == ($signed($past(i_src1)) < $signed($past(i_src2)));
	endproperty
	a_lt: assert property (p_lt) else $error("less compare wrong"); // [RQ5]

	property p_ge;
		s_cmp_start(REL_GE) |=> o_result == ($signed($past(i_src1)) >= $signed($past(i_src2)));
	endproperty
	a_ge: assert property (p_ge) else $error("greater-equal compare wrong"); // [RQ6]

	property p_series;
		i_exec && i_op == OP_CMP && i_form == FORM_SERIES && !o_result |=> !o_result;
	endproperty
	a_series: assert property (p_series) else $error("series form set result"); // [RQ12]

	property p_parallel;
		i_exec && i_op == OP_CMP && i_form == FORM_PARALLEL && o_result |=> o_result;
	endproperty
	a_parallel: assert property (p_parallel) else $error("parallel form lost result"); // [RQ12]

	property p_add;
		s_arith(OP_ADD) |=> o_wr_lo && o_lo_data == 16'($past(i_src1)
			+ ($past(i_three) ? $past(i_src2) : $past(i_dst)));
	endproperty
	a_add: assert property (p_add) else $error("addition result wrong"); // [RQ8]

	property p_sub;
		s_arith(OP_SUB) |=> o_wr_lo && o_lo_data == 16'($past(i_src1)
			- ($past(i_three) ? $past(i_src2) : $past(i_dst)));
	endproperty
	a_sub: assert property (p_sub) else $error("subtraction result wrong"); // [RQ9]

	property p_mul;
		s_arith(OP_MUL) |=> o_wr_lo && o_wr_hi
			&& {o_hi_data, o_lo_data}
			== 32'(int'($signed($past(i_src1))) * int'($signed($past(i_src2))));
	endproperty
	a_mul: assert property (p_mul) else $error("product halves wrong"); // [RQ10]

	property p_div;
		s_arith(OP_DIV) ##0 i_src2 != WORD_ZERO |=> o_wr_lo && o_wr_hi
			&& o_lo_data == 16'($signed($past(i_src1)) / $signed($past(i_src2)));
	endproperty
	a_div: assert property (p_div) else $error("quotient wrong"); // [RQ11]

	property p_div0;
		s_arith(OP_DIV) ##0 i_src2 == WORD_ZERO |=> !o_wr_lo && !o_wr_hi && o_op_error;
	endproperty
	a_div0: assert property (p_div0) else $error("divide by zero not flagged"); // [RQ15]

	sequence s_pulse_again;
		i_exec && i_op != OP_CMP && i_pulse && i_cond && edge_q[i_slot];
	endsequence

	property p_pulse_once;
		s_pulse_again |=> !o_wr_lo && !o_wr_hi;
	endproperty
	a_pulse_once: assert property (p_pulse_once) else $error("pulse ran twice"); // [RQ13]

	property p_mov;
		i_exec && i_op == OP_MOV && i_cond && (!i_pulse || !edge_q[i_slot])
			|=> o_wr_lo && !o_wr_hi && o_lo_data == $past(i_src1);
	endproperty
	a_mov: assert property (p_mov) else $error("transfer wrong"); // [RQ14]

	property p_cmp_nowrite;
		i_exec && i_op == OP_CMP |=> o_done && !o_wr_lo && !o_wr_hi;
	endproperty
	a_cmp_nowrite: assert property (p_cmp_nowrite) else $error("compare wrote a word"); // [RQ7]

	property p_cond_off;
		i_exec && i_op != OP_CMP && !i_cond |=> o_done && !o_wr_lo && !o_wr_hi;
	endproperty
	a_cond_off: assert property (p_cond_off) else $error("write without condition"); // [RQ13]

	property p_err_hold;
		o_op_error && !i_err_clr |=> o_op_error;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag dropped"); // [RQ15]

	property p_div0_keep;
		s_arith(OP_DIV) ##0 i_src2 == WORD_ZERO |=> $stable(o_lo_data) && $stable(o_hi_data);
	endproperty
	a_div0_keep: assert property (p_div0_keep) else $error("divide by zero moved data"); // [RQ15]

	property p_result_hold;
		i_exec && i_op != OP_CMP |=> $stable(o_result);
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("arith changed result"); // [RQ12]

endmodule

// file: shared/pwc_cmp_if.sv
`timescale 1ns/1ps
interface pwc_cmp_if;
	import pwc_pkg::*;

	logic [15:0] first_source_word;
	logic [15:0] second_source_word;
	pwc_rel_type rel;
	logic        cont;

	modport requester (output first_source_word, output second_source_word, output rel,
		input cont);
	modport comparer (input first_source_word, input second_source_word, input rel,
		output cont);
endinterface

// file: shared/pwc_pkg.sv
package pwc_pkg;

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int          WORD_W      = 16;
	localparam int          SLOT_W      = 4;
	localparam int          SLOTS       = 16;
	localparam logic [15:0] WORD_RST    = 16'h0000;
	localparam logic [15:0] WORD_ZERO   = 16'h0000;
	localparam logic        RESULT_RST  = 1'b0;
	localparam logic [15:0] EDGE_RST    = 16'h0000;

	// ----------------------------------------
	// instruction encodings
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_CMP,
		OP_MOV,
		OP_ADD,
		OP_SUB,
		OP_MUL,
		OP_DIV
	} pwc_op_type;

	typedef enum logic [2:0] {
		REL_EQ,
		REL_NE,
		REL_GT,
		REL_LE,
		REL_LT,
		REL_GE
	} pwc_rel_type;

	typedef enum logic [1:0] {
		FORM_START,
		FORM_SERIES,
		FORM_PARALLEL
	} pwc_form_type;

endpackage

// file: test/plc_word_compare_arith_unit_bench.sv
`timescale 1ns/1ps
module plc_word_compare_arith_unit_bench;
	import pwc_pkg::*;
	typedef struct packed {
		logic r, wl, wh, er;
		logic [15:0] lo, hi;
	} pwc_exp_type;
	logic         clk = 0, rst_n = 0, ex = 0, pl = 0, th = 0, cd = 0, ec = 0;
	pwc_op_type   op = OP_CMP;
	pwc_rel_type  rl = REL_EQ;
	pwc_form_type fm = FORM_START;
	logic [3:0]   sl = 4'h0;
	logic [15:0]  s1 = 16'h0000, s2 = 16'h0000, lf = 16'hD413, dst, dst_hi;
	logic         o_done, o_result, o_wr_lo, o_wr_hi, o_op_error;
	logic [15:0]  o_lo, o_hi;
	logic [15:0]  edg = 16'h0000;
	pwc_exp_type  m = '0;
	pwc_exp_type  q[$];
	int           err_total = 0, checks = 0;

	pwc_word_unit i_dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_exec(ex), .i_op(op),
		.i_rel(rl), .i_form(fm), .i_pulse(pl), .i_three(th), .i_cond(cd), .i_slot(sl),
		.i_src1(s1), .i_src2(s2), .i_dst(dst), .i_err_clr(ec), .o_done(o_done),
		.o_result(o_result), .o_wr_lo(o_wr_lo), .o_wr_hi(o_wr_hi), .o_lo_data(o_lo),
		.o_hi_data(o_hi), .o_op_error(o_op_error));
	pwc_word_mem i_mem (.i_core_clk(clk), .i_arst_n(rst_n), .i_wr_lo(o_wr_lo),
		.i_wr_hi(o_wr_hi), .i_lo(o_lo), .i_hi(o_hi), .o_dst(dst), .o_dst_hi(dst_hi));

	initial begin
		forever #50 clk = ~clk;
	end

	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic cmp_bit(input logic x, input logic y);
		checks++;
		if (x !== y) begin
			err_total++;
			$display("Error t=%0t exp=%h got=%h", $time, x, y);
		end
	endtask

	task automatic cmp_word(input logic [15:0] x, input logic [15:0] y);
		checks++;
		if (x !== y) begin
			err_total++;
			$display("Error t=%0t exp=%h got=%h", $time, x, y);
		end
	endtask

	task automatic step(input pwc_op_type o, input pwc_rel_type r, input pwc_form_type f,
		input logic p, input logic t, input logic c, input logic [3:0] s,
		input logic [15:0] a, input logic [15:0] b);
		logic        cv;
		logic        fire;
		logic [31:0] w;
		int          ia;
		int          ib;
		// destination must settle before a read-modify-write
		if (o inside {OP_ADD, OP_SUB} && !t) begin
			@(posedge clk);
			ex <= 1'b0;
		end
		@(posedge clk);
		ex <= 1'b1;
		op <= o;
		rl <= r;
		fm <= f;
		pl <= p;
		th <= t;
		cd <= c;
		sl <= s;
		s1 <= a;
		s2 <= b;
		ia = $signed(a);
		ib = $signed(b);
		fire = c && !(p && edg[s]);
		edg[s] = c;
		m.wl = 1'b0;
		m.wh = 1'b0;
		w = '0;
		case (r)
			REL_EQ: cv = a == b;
			REL_NE: cv = a != b;
			REL_GT: cv = ia > ib;
			REL_LE: cv = ia <= ib;
			REL_LT: cv = ia < ib;
			default: cv = ia >= ib;
		endcase
		if (o == OP_CMP)
			m.r = f == FORM_START ? cv : f == FORM_SERIES ? m.r & cv : m.r | cv;
		else if (fire && o == OP_DIV && b == 16'h0000)
			m.er = 1'b1;
		else if (fire) begin
			case (o)
				OP_MOV: w[15:0] = a;
				OP_ADD: w[15:0] = a + (t ? b : m.lo);
				OP_SUB: w[15:0] = a - (t ? b : m.lo);
				OP_MUL: w = ia * ib;
				default: w = {16'(ia % ib), 16'(ia / ib)};
			endcase
			m.wl = 1'b1;
			m.lo = w[15:0];
			if (o inside {OP_MUL, OP_DIV}) begin
				m.wh = 1'b1;
				m.hi = w[31:16];
			end
		end
		q.push_back(m);
	endtask

	task automatic idle(input logic clr);
		@(posedge clk);
		ex <= 1'b0;
		ec <= clr;
		if (clr)
			m.er = 1'b0;
	endtask

	always @(negedge clk) begin
		if (o_done === 1'b1 && q.size() > 0) begin
			cmp_bit(q[0].r, o_result);
			cmp_bit(q[0].wl, o_wr_lo);
			cmp_bit(q[0].wh, o_wr_hi);
			cmp_word(q[0].lo, o_lo);
			cmp_word(q[0].hi, o_hi);
			cmp_bit(q[0].er, o_op_error);
			void'(q.pop_front());
		end else if (o_done === 1'b1)
			cmp_bit(1'b0, o_done);
	end

	task automatic give_verdict;
		cmp_word(16'h0000, 16'(q.size()));
		cmp_word(m.lo, dst);
		cmp_word(m.hi, dst_hi);
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		give_verdict();
	end

	initial begin
		static logic [15:0] ta[4] = '{16'h0005, 16'h8000, 16'hFFFF, 16'h7FFF};
		static logic [15:0] tb[4] = '{16'h0005, 16'h7FFF, 16'h0001, 16'h8000};
		logic [15:0] ra;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 6; i++)
			for (int j = 0; j < 3; j++)
				for (int k = 0; k < 5; k++) begin
					lf = nxt(lf);
					step(OP_CMP, pwc_rel_type'(i), pwc_form_type'(j), 0, 0, 1, 0,
						k < 4 ? ta[k] : lf, k < 4 ? tb[k] : ~lf);
				end
		step(OP_MOV, REL_EQ, FORM_START, 1, 0, 1, 3, 16'h1234, 0);
		step(OP_MOV, REL_EQ, FORM_START, 1, 0, 1, 3, 16'h5555, 0);
		step(OP_MOV, REL_EQ, FORM_START, 0, 0, 1, 3, 16'hABCD, 0);
		step(OP_ADD, REL_EQ, FORM_START, 1, 1, 0, 3, 16'h0001, 0);
		step(OP_ADD, REL_EQ, FORM_START, 1, 1, 1, 3, 16'hFFFF, 2);
		step(OP_SUB, REL_EQ, FORM_START, 0, 0, 1, 4, 16'h0003, 0);
		step(OP_ADD, REL_EQ, FORM_START, 0, 0, 1, 4, 16'hFFFF, 0);
		step(OP_SUB, REL_EQ, FORM_START, 0, 1, 1, 4, 16'h0000, 1);
		step(OP_MUL, REL_EQ, FORM_START, 0, 0, 1, 5, 16'h8000, 2);
		step(OP_DIV, REL_EQ, FORM_START, 0, 0, 1, 5, 16'hFFF9, 2);
		step(OP_DIV, REL_EQ, FORM_START, 0, 0, 1, 5, 16'h0005, 0);
		idle(1);
		idle(0);
		for (int n = 0; n < 80; n++) begin
			lf = nxt(lf);
			ra = lf;
			lf = nxt(lf);
			step(pwc_op_type'(lf[2:0] % 6), pwc_rel_type'(lf[5:3] % 6),
				pwc_form_type'(lf[7:6] % 3), lf[8], lf[9], lf[10] | lf[11], lf[15:12],
				ra, lf[13] ? lf : 16'h0000);
		end
		idle(0);
		idle(0);
		give_verdict();
	end
endmodule

// file: test/pwc_word_mem.sv
`timescale 1ns/1ps
// ----------------------------------------
// destination word memory, D and D+1
// ----------------------------------------
module pwc_word_mem (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_wr_lo,
	input  wire logic        i_wr_hi,
	input  wire logic [15:0] i_lo,
	input  wire logic [15:0] i_hi,
	output logic [15:0]      o_dst,
	output logic [15:0]      o_dst_hi
);
	logic [15:0] lo_q;
	logic [15:0] hi_q;
	// low-word write in flight is forwarded to o_dst; o_dst_hi reads the stored word
	assign o_dst = i_wr_lo ? i_lo : lo_q;
	assign o_dst_hi = hi_q;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lo_q <= 16'h0000;
			hi_q <= 16'h0000;
		end else begin
			if (i_wr_lo)
				lo_q <= i_lo;
			if (i_wr_hi)
				hi_q <= i_hi;
		end
	end
endmodule
